// ==== rtl/ssl_status_lines.sv ====
// Pin-level control of the eight remote lines, pairing, acknowledge and lamp.
// Assumes the radio link logic sits on ref_clk and exchanges one-cycle pulses.
//
// Functional notes
// - Low direction pin selects lines 0-3 output/input
// - High direction pin selects lines 4-7 output/input
// - Latch select high: commands toggle outputs
// - Latch select low: outputs follow received signal
// - Soft reset pin low resets module; hold, interrupt mask and status registers keep their values here
// - Power-down pin low stops all function; register port and irq stay live here
// - Acknowledge output high on received acknowledgement
// - Pair pin starts pairing; long hold restores defaults
// - Lamp flashes, duration shows current state
// - Send acknowledgement only if enable pin high
// - Sender-only start transmit within 12 ms
// - Sender/receiver start transmit within 1 ms
// - Acknowledge output 100 ms, retriggered
// - Received line high drives same output high
`timescale 1ns/100ps
module ssl_status_lines #(
  parameter int TICK_CYCLES = ssl_pkg::TICK_CYCLES,
  parameter int FACTORY_MS  = ssl_pkg::FACTORY_MS
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Configuration pins
  input  wire logic        low_group_direction_sel,
  input  wire logic        high_group_direction_sel,
  input  wire logic        latch_sel,
  input  wire logic        ack_en,
  input  wire logic        pair_in,
  input  wire logic        soft_reset_n,
  input  wire logic        power_down_n,
  // Remote lines
  input  wire logic [7:0]  remote_lines_in,
  output logic      [7:0]  remote_lines_out,
  output logic      [7:0]  remote_lines_oe,
  // Indicators
  output logic             ack_out,
  output logic             activity_lamp,
  // Link, transmit side
  output logic             tx_start,
  output logic             tx_active,
  output logic      [7:0]  tx_lines,
  // Link, receive side
  input  wire logic        rx_cmd_valid,
  input  wire logic [7:0]  rx_cmd_lines,
  input  wire logic        rx_ack,
  output logic             ack_send,
  // Link, pairing
  output logic             pair_req,
  input  wire logic        pair_done,
  output logic             factory_req,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end
  if (FACTORY_MS < 1 || FACTORY_MS > 65535) begin : g_bad_factory
    $error("FACTORY_MS out of range");
  end

  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [15:0] FACTORY_LAST = 16'(FACTORY_MS);

  function automatic logic [7:0] group_mask(input logic lo, input logic hi);
    group_mask = {{4{hi}}, {4{lo}}};
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [14:0] pins_s;
  logic [7:0]  lines_s;
  logic        dir_lo_s, dir_hi_s, latch_s, ack_en_s, pair_s, soft_n_s, pd_n_s;

  ssl_sync #(.WIDTH(15)) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({power_down_n, soft_reset_n, pair_in, ack_en, latch_sel,
                high_group_direction_sel, low_group_direction_sel, remote_lines_in}),
    .sync_out (pins_s)
  );

  assign {pd_n_s, soft_n_s, pair_s, ack_en_s, latch_s, dir_hi_s, dir_lo_s, lines_s} = pins_s;

  // Powered and out of soft reset; the pull-up on soft reset is the pad's job
  logic run;
  assign run = pd_n_s & soft_n_s;

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_reg;
  logic              tick_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  logic [7:0] hold_reg;

  ssl_timer_if #(.W(ssl_pkg::TMR_W)) ack_t ();
  ssl_timer_if #(.W(ssl_pkg::TMR_W)) hold_t ();

  assign ack_t.tick     = tick_reg;
  assign ack_t.clear    = ~run;
  assign ack_t.restart  = run & rx_ack;
  assign ack_t.load     = 16'(ssl_pkg::ACK_HOLD_MS);
  assign hold_t.tick    = tick_reg;
  assign hold_t.clear   = ~run;
  assign hold_t.restart = run & rx_cmd_valid;
  assign hold_t.load    = {8'h00, hold_reg};

  ssl_ms_timer u_ack_tmr (
    .ref_clk (ref_clk),
    .reset   (reset),
    .t       (ack_t)
  );

  ssl_ms_timer u_hold_tmr (
    .ref_clk (ref_clk),
    .reset   (reset),
    .t       (hold_t)
  );

  // ----------------------------------------------------------------
  // Direction and transmit
  // ----------------------------------------------------------------
  logic [7:0] in_mask, out_mask, lines_in_m, prev_in_reg, rise;
  logic       pairing_reg;

  assign in_mask    = group_mask(dir_lo_s, dir_hi_s);
  assign out_mask   = ~in_mask;
  assign lines_in_m = lines_s & in_mask;
  assign rise       = lines_in_m & ~prev_in_reg;

  // Start is raised the cycle after the edge, well inside either wake limit
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prev_in_reg <= '0;
      tx_start    <= 1'b0;
      tx_active   <= 1'b0;
      tx_lines    <= '0;
    end else if (!run) begin
      prev_in_reg <= '0;
      tx_start    <= 1'b0;
      tx_active   <= 1'b0;
      tx_lines    <= '0;
    end else begin
      prev_in_reg <= lines_in_m;
      tx_start    <= (|rise) & ~pairing_reg;
      tx_active   <= (|lines_in_m) & ~pairing_reg;
      tx_lines    <= lines_in_m;
    end
  end

  // ----------------------------------------------------------------
  // Received commands to outputs
  // ----------------------------------------------------------------
  logic [7:0] rx_prev_reg, rx_cmd_m;
  assign rx_cmd_m = rx_cmd_lines & out_mask;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      remote_lines_out <= '0;
      rx_prev_reg      <= '0;
    end else if (!run) begin
      remote_lines_out <= '0;
      rx_prev_reg      <= '0;
    end else if (rx_cmd_valid) begin
      rx_prev_reg <= rx_cmd_m;
      if (latch_s) begin
        remote_lines_out <= (remote_lines_out ^ (rx_cmd_m & ~rx_prev_reg)) & out_mask;
      end else begin
        remote_lines_out <= rx_cmd_m;
      end
    end else if (!hold_t.busy) begin
      // Session lapsed: momentary lines drop, latched ones keep state
      rx_prev_reg <= '0;
      if (!latch_s) begin
        remote_lines_out <= '0;
      end else begin
        remote_lines_out <= remote_lines_out & out_mask;
      end
    end else begin
      remote_lines_out <= remote_lines_out & out_mask;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      remote_lines_oe <= '0;
    end else begin
      remote_lines_oe <= out_mask & {8{run}};
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack_send <= 1'b0;
      ack_out  <= 1'b0;
    end else begin
      ack_send <= run & rx_cmd_valid & ack_en_s;
      ack_out  <= run & ack_t.busy;
    end
  end

  // ----------------------------------------------------------------
  // Pairing and factory default
  // ----------------------------------------------------------------
  logic        pair_prev_reg;
  logic [15:0] pair_hold_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pair_prev_reg <= 1'b0;
      pair_req      <= 1'b0;
      pairing_reg   <= 1'b0;
    end else if (!run) begin
      pair_prev_reg <= 1'b0;
      pair_req      <= 1'b0;
      pairing_reg   <= 1'b0;
    end else begin
      pair_prev_reg <= pair_s;
      pair_req      <= pair_s & ~pair_prev_reg;
      if (pair_s & ~pair_prev_reg) begin
        pairing_reg <= 1'b1;
      end else if (pair_done) begin
        pairing_reg <= 1'b0;
      end
    end
  end

  // Holding the pair pin is the sequence; fires once per hold
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pair_hold_reg <= '0;
      factory_req   <= 1'b0;
    end else if (!run || !pair_s) begin
      pair_hold_reg <= '0;
      factory_req   <= 1'b0;
    end else begin
      factory_req <= 1'b0;
      if (tick_reg && pair_hold_reg != FACTORY_LAST) begin
        pair_hold_reg <= pair_hold_reg + 1'b1;
        factory_req   <= (pair_hold_reg == FACTORY_LAST - 16'h0001);
      end
    end
  end

  // ----------------------------------------------------------------
  // Activity lamp
  // ----------------------------------------------------------------
  ssl_pkg::ssl_mode_e mode_reg;
  logic [15:0]        flash_cnt_reg;
  logic [15:0]        shown_cnt_reg;
  logic               blink_reg;
  logic [15:0]        half_ms;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_reg <= ssl_pkg::SSL_OFF;
    end else if (!run) begin
      mode_reg <= ssl_pkg::SSL_OFF;
    end else if (pair_done) begin
      // Done arrives while still searching, so it must outrank the search flag
      mode_reg <= ssl_pkg::SSL_PAIRED;
    end else if (pairing_reg) begin
      mode_reg <= ssl_pkg::SSL_SEARCH;
    end else if (mode_reg == ssl_pkg::SSL_PAIRED &&
                 shown_cnt_reg != 16'(ssl_pkg::PAIRED_SHOW_MS)) begin
      mode_reg <= ssl_pkg::SSL_PAIRED;
    end else if (tx_active) begin
      mode_reg <= ssl_pkg::SSL_TX;
    end else if (hold_t.busy) begin
      mode_reg <= ssl_pkg::SSL_RX;
    end else begin
      mode_reg <= ssl_pkg::SSL_IDLE;
    end
  end

  assign half_ms = (mode_reg == ssl_pkg::SSL_SEARCH) ? 16'(ssl_pkg::SLOW_HALF_MS)
                                                     : 16'(ssl_pkg::FAST_HALF_MS);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flash_cnt_reg <= '0;
      shown_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end else if (pair_done || (mode_reg != ssl_pkg::SSL_SEARCH &&
                               mode_reg != ssl_pkg::SSL_PAIRED)) begin
      // Fresh window on pairing, else a long search would pin the paired display
      flash_cnt_reg <= '0;
      shown_cnt_reg <= '0;
      blink_reg     <= 1'b1;
    end else if (tick_reg) begin
      if (shown_cnt_reg != 16'hFFFF) begin
        shown_cnt_reg <= shown_cnt_reg + 1'b1;
      end
      if (flash_cnt_reg >= half_ms - 16'h0001) begin
        flash_cnt_reg <= '0;
        blink_reg     <= ~blink_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      activity_lamp <= 1'b0;
    end else begin
      case (mode_reg)
        ssl_pkg::SSL_SEARCH,
        ssl_pkg::SSL_PAIRED: activity_lamp <= blink_reg;
        ssl_pkg::SSL_TX,
        ssl_pkg::SSL_RX:     activity_lamp <= 1'b1;
        default:             activity_lamp <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers and interrupt
  // ----------------------------------------------------------------
  logic [ssl_pkg::INT_W-1:0] int_stat_reg, int_mask_reg, int_ev;
  logic                      wr_stat, wr_mask, wr_hold;

  assign int_ev = {factory_req, pair_done & run, rx_ack & run, rx_cmd_valid & run, tx_start};
  assign wr_stat = reg_wr && reg_addr == ssl_pkg::OFF_INT_STAT;
  assign wr_mask = reg_wr && reg_addr == ssl_pkg::OFF_INT_MASK;
  assign wr_hold = reg_wr && reg_addr == ssl_pkg::OFF_HOLD;

  // New events win over a write-one-to-clear in the same cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~({ssl_pkg::INT_W{wr_stat}} &
                       reg_wdata[ssl_pkg::INT_W-1:0])) | int_ev;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      int_mask_reg <= '0;
      hold_reg     <= ssl_pkg::HOLD_RST;
    end else begin
      if (wr_mask) begin
        int_mask_reg <= reg_wdata[ssl_pkg::INT_W-1:0];
      end
      // Zero would drop momentary outputs between packets
      if (wr_hold && reg_wdata[7:0] != 8'h00) begin
        hold_reg <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ssl_pkg::OFF_LINES: begin
          reg_rdata <= '0;
          reg_rdata[ssl_pkg::LINES_OUT_LSB +: 8] <= remote_lines_out;
          reg_rdata[ssl_pkg::LINES_IN_LSB +: 8]  <= lines_in_m;
          reg_rdata[ssl_pkg::LINES_DIR_LSB +: 2] <= {dir_hi_s, dir_lo_s};
          reg_rdata[ssl_pkg::LINES_RUN_BIT]      <= run;
        end
        ssl_pkg::OFF_HOLD:     reg_rdata <= {24'h000000, hold_reg};
        ssl_pkg::OFF_INT_STAT: reg_rdata <= {27'h0000000, int_stat_reg};
        ssl_pkg::OFF_INT_MASK: reg_rdata <= {27'h0000000, int_mask_reg};
        default:               reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // ssl_status_lines

// ==== rtl/ssl_pkg.sv ====
// Shared constants for the status line control block.
// Assumes a single 200 MHz clock and a plain register port.
package ssl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 200_000_000;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int TMR_W          = 16;
  localparam int ACK_HOLD_MS    = 100;
  localparam int SENDER_WAKE_MS = 12;
  localparam int BOTH_WAKE_MS   = 1;
  localparam int HOLD_RST_MS    = 25;
  localparam int FACTORY_MS     = 10000;
  localparam int SLOW_HALF_MS   = 500;
  localparam int FAST_HALF_MS   = 100;
  localparam int PAIRED_SHOW_MS = 2000;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_LINES    = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_HOLD     = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 4'hC;
  localparam int LINES_OUT_LSB = 0;
  localparam int LINES_IN_LSB  = 8;
  localparam int LINES_DIR_LSB = 16;
  localparam int LINES_RUN_BIT = 18;
  localparam logic [7:0] HOLD_RST = 8'(HOLD_RST_MS);

  // Interrupt bits
  localparam int INT_W        = 5;
  localparam int INT_TX_START = 0;
  localparam int INT_RX_CMD   = 1;
  localparam int INT_ACK_RX   = 2;
  localparam int INT_PAIRED   = 3;
  localparam int INT_FACTORY  = 4;

  // Lamp modes
  typedef enum logic [2:0] {
    SSL_OFF,
    SSL_IDLE,
    SSL_SEARCH,
    SSL_PAIRED,
    SSL_TX,
    SSL_RX
  } ssl_mode_e;

endpackage

// ==== rtl/ssl_timer_if.sv ====
// Control group of one retriggerable millisecond timer.
// Assumes the owner supplies a one-cycle millisecond tick.
`timescale 1ns/100ps
interface ssl_timer_if #(parameter int W = 16);
  logic         tick;
  logic         clear;
  logic         restart;
  logic [W-1:0] load;
  logic         busy;
  modport ctrl (output tick, output clear, output restart, output load, input busy);
  modport tmr  (input tick, input clear, input restart, input load, output busy);
endinterface

// ==== rtl/ssl_sync.sv ====
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous levels; resets to zero.
`timescale 1ns/100ps
module ssl_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // ssl_sync

// ==== rtl/ssl_ms_timer.sv ====
// Retriggerable down-counter in millisecond ticks.
// Assumes restart and clear come from the same clock domain.
`timescale 1ns/100ps
module ssl_ms_timer (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Control group
  ssl_timer_if.tmr  t
);

  logic [$bits(t.load)-1:0] cnt_reg;

  // A restart wins over the tick but not over clear, so a new event re-arms the full interval
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (t.clear) begin
      cnt_reg <= '0;
    end else if (t.restart) begin
      cnt_reg <= t.load;
    end else if (t.tick && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign t.busy = (cnt_reg != '0);

endmodule // ssl_ms_timer

// ==== dv/ssl_status_lines_sva.sv ====
// Port assertions for the status line block.
// Assumes one clock, async active-high reset; bound to every instance.
`timescale 1ns/100ps
module ssl_status_lines_sva #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // Pins
  input wire logic       low_group_direction_sel,
  input wire logic       high_group_direction_sel,
  input wire logic       ack_en,
  input wire logic       pair_in,
  input wire logic       soft_reset_n,
  input wire logic       power_down_n,
  input wire logic [7:0] remote_lines_in,
  input wire logic [7:0] remote_lines_oe,
  input wire logic       ack_out,
  input wire logic       activity_lamp,
  // Link
  input wire logic       tx_start,
  input wire logic       tx_active,
  input wire logic       rx_cmd_valid,
  input wire logic       rx_ack,
  input wire logic       ack_send
);
  logic run_pins;
  int   ack_cnt_reg;

  assign run_pins = power_down_n && soft_reset_n;

  // Cycles since the last acknowledge, saturating
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      ack_cnt_reg <= 0;
    else if (rx_ack)
      ack_cnt_reg <= 0;
    else if (ack_cnt_reg < 100000)
      ack_cnt_reg <= ack_cnt_reg + 1;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_low_dir:
  assert property (($stable(low_group_direction_sel) && run_pins)[*6] |->
    remote_lines_oe[3:0] == {4{!low_group_direction_sel}}) else $error("low group direction");
  a_high_dir:
  assert property (($stable(high_group_direction_sel) && run_pins)[*6] |->
    remote_lines_oe[7:4] == {4{!high_group_direction_sel}}) else $error("high group direction");
  a_ack_send_on:
  assert property (((ack_en && run_pins)[*6] ##0 rx_cmd_valid) |=> ack_send)
    else $error("no acknowledge sent");
  a_ack_send_off:
  assert property ((!ack_en[*4] ##0 rx_cmd_valid) |=> !ack_send)
    else $error("acknowledge sent while disabled");
  a_ack_out_rise:
  assert property ((run_pins[*6] ##0 rx_ack) |-> ##2 ack_out) else $error("ack output late");
  a_ack_min_hold:
  assert property ($fell(ack_out) && run_pins |-> ack_cnt_reg >= 99 * TICK_CYCLES)
    else $error("ack output short");
  a_ack_max_hold:
  assert property (ack_out |-> ack_cnt_reg <= 101 * TICK_CYCLES + 4) else $error("ack output long");
  a_tx_latency:
  assert property (((run_pins && high_group_direction_sel && !pair_in)[*6] ##0
    (|(remote_lines_in[7:4] & ~$past(remote_lines_in[7:4])))) |-> ##[1:4] tx_start)
    else $error("transmit start late");
  a_tx_one_pulse:
  assert property (tx_start |-> tx_active ##1 !tx_start) else $error("bad transmit pulse");
  a_pd_quiet:
  assert property (!power_down_n[*6] |-> remote_lines_oe == 8'h00 && !tx_active &&
    !ack_out && !activity_lamp) else $error("active while powered down");
  a_srst_quiet:
  assert property (!soft_reset_n[*6] |-> remote_lines_oe == 8'h00 && !tx_active &&
    !ack_out && !activity_lamp) else $error("active in soft reset");
endmodule // ssl_status_lines_sva

bind ssl_status_lines ssl_status_lines_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .ref_clk, .reset, .low_group_direction_sel, .high_group_direction_sel, .ack_en, .pair_in,
  .soft_reset_n, .power_down_n, .remote_lines_in, .remote_lines_oe, .ack_out, .activity_lamp,
  .tx_start, .tx_active, .rx_cmd_valid, .rx_ack, .ack_send);

// ==== dv/ssl_app_model.sv ====
// Application side of the pins: buttons on input lines, loads on outputs.
// Assumes the bench sets the buttons and the power-down level.
`timescale 1ns/100ps
module ssl_app_model (
  // Bench controls
  input  wire logic       pd_on,
  input  wire logic [7:0] press,
  // Block pins
  input  wire logic [7:0] remote_lines_oe,
  input  wire logic [7:0] remote_lines_out,
  output logic      [7:0] remote_lines_in,
  output logic            power_down_n
);
  // Always a firm level, never left floating
  assign power_down_n = pd_on;
  // Released buttons leave a pull-down on the line
  assign remote_lines_in = (remote_lines_oe & remote_lines_out) | (~remote_lines_oe & press);
endmodule // ssl_app_model

// ==== dv/ssl_status_lines_test.sv ====
// Self-checking bench for the status line block.
// Assumes short tick (10 cycles) and factory hold (5 ticks) parameters.
`timescale 1ns/100ps
module ssl_status_lines_test;
  logic        ref_clk = 1'h0, reset = 1'h1, pd_on = 1'h1, soft_reset_n = 1'h1;
  logic        low_group_direction_sel = 1'h0, high_group_direction_sel = 1'h1;
  logic        latch_sel = 1'h0, ack_en = 1'h1, pair_in = 1'h0, pair_done = 1'h0;
  logic        rx_cmd_valid = 1'h0, rx_ack = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, lamp;
  logic [7:0]  press = 8'h00, rx_cmd_lines = 8'h00;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0]  remote_lines_in, remote_lines_out, remote_lines_oe, tx_lines;
  logic        power_down_n, ack_out, activity_lamp, tx_start, tx_active, ack_send;
  logic        pair_req, factory_req, irq;
  int          error_cnt = 0, checked = 0, cycles = 0, n;

  always #2.5 ref_clk = ~ref_clk;

  ssl_app_model u_app (.pd_on, .press, .remote_lines_oe, .remote_lines_out,
    .remote_lines_in, .power_down_n);
  ssl_status_lines #(.TICK_CYCLES(10), .FACTORY_MS(5)) dut (.ref_clk, .reset,
    .low_group_direction_sel, .high_group_direction_sel, .latch_sel, .ack_en, .pair_in,
    .soft_reset_n, .power_down_n, .remote_lines_in, .remote_lines_out, .remote_lines_oe,
    .ack_out, .activity_lamp, .tx_start, .tx_active, .tx_lines, .rx_cmd_valid, .rx_cmd_lines,
    .rx_ack, .ack_send, .pair_req, .pair_done, .factory_req, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'h1; end
    @(posedge ref_clk) reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk) begin reg_addr <= a; reg_rd <= 1'h1; end
    @(posedge ref_clk) reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic rx(input logic [7:0] v);
    @(posedge ref_clk) begin rx_cmd_lines <= v; rx_cmd_valid <= 1'h1; end
    @(posedge ref_clk) rx_cmd_valid <= 1'h0;
    #1;
  endtask
  task automatic ack_rx(input int k);
    @(posedge ref_clk) rx_ack <= 1'h1;
    @(posedge ref_clk) rx_ack <= 1'h0;
    cyc(k);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Expected run is about 3900 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    // --------------------------------------------------------------
    // Registers and directions
    // --------------------------------------------------------------
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk) begin
        low_group_direction_sel <= (i == 1);
        high_group_direction_sel <= (i != 1);
      end
      cyc(8);
      chk(remote_lines_oe, (i == 1) ? 8'hF0 : 8'h0F);
    end
    rd(ssl_pkg::OFF_HOLD, 32'h19);
    rd(ssl_pkg::OFF_INT_MASK, 32'h0);
    rd(4'h2, 32'h0);
    wr(ssl_pkg::OFF_HOLD, 32'h0);
    rd(ssl_pkg::OFF_HOLD, 32'h19);
    wr(ssl_pkg::OFF_HOLD, 32'h3);
    rd(ssl_pkg::OFF_LINES, 32'h0006_0000);
    // --------------------------------------------------------------
    // Momentary, latched and acknowledge sending
    // --------------------------------------------------------------
    rx(8'hF5);
    chk(remote_lines_out, 8'h05);
    chk(ack_send, 1'h1);
    cyc(12);
    chk(remote_lines_out, 8'h05);
    cyc(40);
    chk(remote_lines_out, 8'h00);
    @(posedge ref_clk) ack_en <= 1'h0;
    cyc(4);
    rx(8'h01);
    chk(ack_send, 1'h0);
    cyc(45);
    @(posedge ref_clk) latch_sel <= 1'h1;
    cyc(4);
    for (int i = 0; i < 3; i++) begin
      rx((i == 1) ? 8'h00 : 8'h01);
      chk(remote_lines_out, (i == 2) ? 8'h00 : 8'h01);
    end
    @(posedge ref_clk) latch_sel <= 1'h0;
    // Interrupt: pending but masked, unmasked, cleared
    chk(irq, 1'h0);
    wr(ssl_pkg::OFF_INT_MASK, 32'h3);
    cyc(2);
    chk(irq, 1'h1);
    wr(ssl_pkg::OFF_INT_STAT, 32'h1F);
    rd(ssl_pkg::OFF_INT_STAT, 32'h0);
    chk(irq, 1'h0);
    // --------------------------------------------------------------
    // Transmit, acknowledge, pairing, lamp
    // --------------------------------------------------------------
    @(posedge ref_clk) press <= 8'h20;
    for (n = 0; n < 8 && tx_start !== 1'h1; n++) cyc(1);
    chk(n < 6, 1'h1);
    chk(tx_lines, 8'h20);
    rd(ssl_pkg::OFF_LINES, 32'h0006_2000);
    chk(irq, 1'h1);
    @(posedge ref_clk) press <= 8'h00;
    ack_rx(3);
    chk(ack_out, 1'h1);
    cyc(600);
    ack_rx(900);
    chk(ack_out, 1'h1);
    cyc(150);
    chk(ack_out, 1'h0);
    @(posedge ref_clk) pair_in <= 1'h1;
    for (n = 0; n < 8 && pair_req !== 1'h1; n++) cyc(1);
    chk(n < 6, 1'h1);
    for (n = 0; n < 100 && factory_req !== 1'h1; n++) cyc(1);
    chk(n < 80, 1'h1);
    @(posedge ref_clk) pair_in <= 1'h0;
    @(posedge ref_clk) pair_done <= 1'h1;
    @(posedge ref_clk) pair_done <= 1'h0;
    for (int i = 0; i < 2; i++) begin
      cyc(1);
      lamp = activity_lamp;
      for (n = 1; n < 1200 && activity_lamp === lamp; n++) cyc(1);
    end
    chk(n >= 990 && n <= 1010, 1'h1);
    rd(ssl_pkg::OFF_INT_STAT, 32'h1D);
    // --------------------------------------------------------------
    // Power down, then soft reset
    // --------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk) begin pd_on <= (i != 0); soft_reset_n <= (i == 0); end
      cyc(6);
      chk(remote_lines_oe, 8'h00);
      rd(ssl_pkg::OFF_LINES, 32'h0002_0000);
      @(posedge ref_clk) begin pd_on <= 1'h1; soft_reset_n <= 1'h1; end
      cyc(6);
      chk(remote_lines_oe, 8'h0F);
    end
    end_of_test();
  end
endmodule // ssl_status_lines_test
